// ---- e3fm_frame_maint.sv ----
// Purpose: Receive E3 frame alignment maintenance, error counter,
//          loss of signal and interrupt registers.
// Assumes: Line clock is slow against clock and sampled as a level.
// Notes:   Search state locks on the first pattern seen.
`timescale 1ns/1ps
`default_nettype none
`include "e3fm_defs.svh"
module e3fm_frame_maint (
    input  wire logic       clock,
    input  wire logic       sys_rst,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output var  logic [7:0] reg_rdata,
    input  wire logic       line_clk_in,
    input  wire logic       line_data_positive_input,
    input  wire logic       line_data_negative_input,
    input  wire logic       external_signal_loss_input,
    output var  logic       out_of_frame_indicator,
    output var  logic       loss_of_frame_indicator,
    output var  logic       signal_loss_indicator,
    output logic            irq
);
    e3fm_pkg::e3fm_state_e state_r;
    e3fm_pkg::e3fm_state_e state_nxt;
    logic [3:0]  sync_q;
    logic        clk_prev_r;
    logic [9:0]  shift_r;
    logic [10:0] bit_pos_r;
    logic [2:0]  miss_r;
    logic [4:0]  dwell_r;
    logic [15:0] err_cnt_r;
    logic [7:0]  io_r;
    logic        algo_r;
    logic [7:0]  int_stat_r;
    logic [7:0]  int_mask_r;
    logic        los_prev_r;
    logic        line_los;
    logic        oof_set;
    logic        lof_set;

    // Synchronise line clock, data and external loss pins
    e3fm_sync #(.W(4)) u_sync (
        .clock   (clock),
        .sys_rst (sys_rst),
        .d       ({external_signal_loss_input, line_data_negative_input,
                   line_data_positive_input, line_clk_in}),
        .q       (sync_q)
    );

    // Bit strobe on the chosen edge of the sampled line clock
    wire       clk_inv  = io_r[`E3FM_IO_CLK_INV_BIT];
    wire       bit_en   = clk_inv ? (clk_prev_r && !sync_q[0])
                                  : (!clk_prev_r && sync_q[0]);
    wire       bit_val  = sync_q[1] | sync_q[2];
    wire       ext_los  = sync_q[3];
    wire [9:0] shift_nxt = {shift_r[8:0], bit_val};
    wire       fas_ok   = shift_nxt == `E3FM_FAS_PATTERN;
    wire       locked   = (state_r == e3fm_pkg::ST_IN_FRAME) ||
                          (state_r == e3fm_pkg::ST_OOF);
    wire       check    = bit_en && locked &&
                          bit_pos_r == `E3FM_FAS_LAST;   // see R1
    wire       err_evt  = check && !fas_ok;
    wire [4:0] dwell_lim = algo_r ? `E3FM_DWELL_SHORT
                                  : `E3FM_DWELL_LONG;     // see R12

    // Register port decode
    wire wr_io   = reg_wr && reg_addr == `E3FM_ADDR_IO_CTRL;
    wire wr_cfg  = reg_wr && reg_addr == `E3FM_ADDR_CFG_STAT;
    wire wr_int  = reg_wr && reg_addr == `E3FM_ADDR_INT_STAT;
    wire wr_mask = reg_wr && reg_addr == `E3FM_ADDR_INT_MASK;
    wire rd_int  = reg_rd && reg_addr == `E3FM_ADDR_INT_STAT;
    wire rd_hi   = reg_rd && reg_addr == `E3FM_ADDR_ERR_HIGH;
    wire rd_lo   = reg_rd && reg_addr == `E3FM_ADDR_ERR_LOW;
    wire reframe = wr_io && reg_wdata[`E3FM_IO_REFRAME_BIT]; // see R5

    // Loss of signal from line content or the external input
    e3fm_los_detect u_los (
        .clock   (clock),
        .sys_rst (sys_rst),
        .bit_en  (bit_en),
        .bit_val (bit_val),
        .los_r   (line_los)
    );
    wire los_now = line_los | ext_los;                  // see R10 R11

    // Framing state transitions
    always_comb begin
        state_nxt = state_r;
        oof_set   = 1'b0;
        lof_set   = 1'b0;
        if (reframe) begin
            state_nxt = e3fm_pkg::ST_SEARCH;            // see R5
            oof_set   = 1'b1;                           // see R7
            lof_set   = 1'b1;
        end else begin
            case (state_r)
                e3fm_pkg::ST_SEARCH: begin
                    if (bit_en && fas_ok) begin
                        state_nxt = e3fm_pkg::ST_IN_FRAME;
                        oof_set   = 1'b1;
                        lof_set   = 1'b1;
                    end
                end
                e3fm_pkg::ST_IN_FRAME: begin
                    if (err_evt && miss_r == `E3FM_MISS_LIMIT - 3'd1) begin
                        state_nxt = e3fm_pkg::ST_OOF;   // see R2
                        oof_set   = 1'b1;
                    end
                end
                e3fm_pkg::ST_OOF: begin
                    if (check && fas_ok) begin
                        state_nxt = e3fm_pkg::ST_IN_FRAME;
                        oof_set   = 1'b1;
                    end else if (err_evt &&
                                 dwell_r + 5'd1 >= dwell_lim) begin
                        state_nxt = e3fm_pkg::ST_LOF;   // see R12
                        lof_set   = 1'b1;
                    end
                end
                default: begin
                    state_nxt = e3fm_pkg::ST_SEARCH;
                end
            endcase
        end
    end

    // State, bit position and pattern shifter
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state_r    <= e3fm_pkg::ST_SEARCH;
            clk_prev_r <= 1'b0;
            shift_r    <= 10'h000;
            bit_pos_r  <= 11'h000;
        end else begin
            state_r    <= state_nxt;
            clk_prev_r <= sync_q[0];
            if (bit_en)
                shift_r <= shift_nxt;
            if (state_r == e3fm_pkg::ST_SEARCH && bit_en && fas_ok)
                bit_pos_r <= `E3FM_FAS_NEXT;
            else if (bit_en)
                bit_pos_r <= (bit_pos_r == `E3FM_FRAME_BITS - 11'd1) ?
                             11'h000 : bit_pos_r + 11'd1;
        end
    end

    // Consecutive misses while in frame, frames spent out of frame
    always_ff @(posedge clock) begin
        if (sys_rst || state_nxt != state_r) begin
            miss_r  <= 3'h0;
            dwell_r <= 5'h00;
        end else if (check) begin
            miss_r  <= fas_ok ? 3'h0 : miss_r + 3'h1;   // see R2
            dwell_r <= dwell_r + 5'h01;
        end
    end

    // Framing pins from the next state: in frame 00, dwell 01, loss 11; signal loss pin from los_now
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            out_of_frame_indicator  <= 1'b1;
            loss_of_frame_indicator <= 1'b1;
            signal_loss_indicator   <= 1'b0;
        end else begin
            out_of_frame_indicator  <=
                state_nxt != e3fm_pkg::ST_IN_FRAME;     // see R6 R9
            loss_of_frame_indicator <=
                state_nxt == e3fm_pkg::ST_SEARCH ||
                state_nxt == e3fm_pkg::ST_LOF;          // see R6 R9
            signal_loss_indicator   <= los_now;         // see R14 R15
        end
    end

    // Error counter: read clears the byte, increment wins, saturates
    wire [15:0] cnt_base = {rd_hi ? 8'h00 : err_cnt_r[15:8],
                            rd_lo ? 8'h00 : err_cnt_r[7:0]};  // see R4
    wire [15:0] cnt_nxt  = (err_evt && cnt_base != `E3FM_CNT_MAX) ?
                           cnt_base + 16'h0001 : cnt_base;    // see R3 R16

    always_ff @(posedge clock) begin
        if (sys_rst)
            err_cnt_r <= 16'h0000;
        else
            err_cnt_r <= cnt_nxt;
    end

    // Control registers
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            io_r       <= `E3FM_IO_RESET;
            algo_r     <= 1'b0;
            int_mask_r <= 8'h00;
        end else begin
            if (wr_io)
                io_r <= reg_wdata & `E3FM_IO_WR_MASK;
            if (wr_cfg)
                algo_r <= reg_wdata[`E3FM_CFG_ALGO_BIT];
            if (wr_mask)
                int_mask_r <= reg_wdata & `E3FM_INT_USED;
        end
    end

    // Sticky interrupt status: read or write-one clears, set wins
    wire [7:0] int_set = ({4'h0, oof_set, lof_set, 2'b00} |
                          {6'h00, los_now != los_prev_r, 1'b0});
    wire [7:0] int_clr = (rd_int ? 8'hFF : 8'h00) |
                         (wr_int ? reg_wdata : 8'h00);
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            int_stat_r <= 8'h00;
            los_prev_r <= 1'b0;
        end else begin
            int_stat_r <= (int_stat_r & ~int_clr) | int_set; // see R13 R7
            los_prev_r <= los_now;
        end
    end

    assign irq = |(int_stat_r & int_mask_r);

    // Read multiplexer; data valid only in the cycle after the strobe
    wire [7:0] cfg_rd = {algo_r, loss_of_frame_indicator,
                         out_of_frame_indicator, signal_loss_indicator,
                         4'h0};                          // see R8 R14
    wire [7:0] rd_mux =
        (reg_addr == `E3FM_ADDR_IO_CTRL)  ? io_r :
        (reg_addr == `E3FM_ADDR_CFG_STAT) ? cfg_rd :
        (reg_addr == `E3FM_ADDR_INT_STAT) ? int_stat_r :
        (reg_addr == `E3FM_ADDR_INT_MASK) ? int_mask_r :
        (reg_addr == `E3FM_ADDR_ERR_HIGH) ? err_cnt_r[15:8] :
        (reg_addr == `E3FM_ADDR_ERR_LOW)  ? err_cnt_r[7:0] : 8'h00;

    always_ff @(posedge clock) begin
        if (sys_rst)
            reg_rdata <= 8'h00;
        else
            reg_rdata <= reg_rd ? rd_mux : 8'h00;
    end

    // Checks
    property p_pins_valid;
        @(posedge clock) disable iff (sys_rst)
        !(loss_of_frame_indicator && !out_of_frame_indicator);
    endproperty
    a_pins_valid: assert property (p_pins_valid) // see R9
        else $error("invalid framing pin combination");

    property p_reframe_pins;
        @(posedge clock) disable iff (sys_rst)
        reframe |=> (out_of_frame_indicator && loss_of_frame_indicator &&
                     state_r == e3fm_pkg::ST_SEARCH);
    endproperty
    a_reframe_pins: assert property (p_reframe_pins) // see R6
        else $error("reframe did not raise framing pins");

    property p_reframe_irq;
        @(posedge clock) disable iff (sys_rst)
        reframe |=> (int_stat_r[`E3FM_INT_OOF_BIT] &&
                     int_stat_r[`E3FM_INT_LOF_BIT]);
    endproperty
    a_reframe_irq: assert property (p_reframe_irq) // see R7
        else $error("reframe did not raise change interrupts");

    property p_reframe_status;
        @(posedge clock) disable iff (sys_rst)
        reframe ##[1:2] (reg_rd && reg_addr == `E3FM_ADDR_CFG_STAT)
            |=> (reg_rdata[6:5] == 2'b11);
    endproperty
    a_reframe_status: assert property (p_reframe_status) // see R8
        else $error("status bits not set after reframe");

    property p_oof_after4;
        @(posedge clock) disable iff (sys_rst)
        (!reframe && state_r == e3fm_pkg::ST_IN_FRAME && err_evt &&
         miss_r == 3'd3) |=> (state_r == e3fm_pkg::ST_OOF);
    endproperty
    a_oof_after4: assert property (p_oof_after4) // see R2
        else $error("fourth miss did not enter out of frame");

    property p_isolated;
        @(posedge clock) disable iff (sys_rst)
        (!reframe && state_r == e3fm_pkg::ST_IN_FRAME && miss_r < 3'd3)
            |=> (state_r == e3fm_pkg::ST_IN_FRAME);
    endproperty
    a_isolated: assert property (p_isolated) // see R2
        else $error("left frame before four misses");

    property p_dwell;
        @(posedge clock) disable iff (sys_rst)
        (state_r == e3fm_pkg::ST_OOF) |-> (dwell_r < dwell_lim);
    endproperty
    a_dwell: assert property (p_dwell) // see R12
        else $error("out of frame dwell exceeded");

    property p_cnt_inc;
        @(posedge clock) disable iff (sys_rst)
        (err_evt && !rd_hi && !rd_lo && err_cnt_r != 16'hFFFF)
            |=> (err_cnt_r == $past(err_cnt_r) + 16'h0001);
    endproperty
    a_cnt_inc: assert property (p_cnt_inc) // see R3
        else $error("error counter did not increment");

    property p_cnt_clear;
        @(posedge clock) disable iff (sys_rst)
        (rd_lo && !err_evt) |=> (err_cnt_r[7:0] == 8'h00);
    endproperty
    a_cnt_clear: assert property (p_cnt_clear) // see R4
        else $error("low counter byte not cleared by read");

    property p_cnt_sat;
        @(posedge clock) disable iff (sys_rst)
        (err_cnt_r == 16'hFFFF && !rd_hi && !rd_lo)
            |=> (err_cnt_r == 16'hFFFF);
    endproperty
    a_cnt_sat: assert property (p_cnt_sat) // see R16
        else $error("error counter wrapped");

    property p_ext_los;
        @(posedge clock) disable iff (sys_rst)
        ext_los |=> signal_loss_indicator;
    endproperty
    a_ext_los: assert property (p_ext_los) // see R11
        else $error("external loss not reflected on pin");

    property p_los_irq;
        @(posedge clock) disable iff (sys_rst)
        (los_now != los_prev_r) |=> int_stat_r[`E3FM_INT_LOS_BIT];
    endproperty
    a_los_irq: assert property (p_los_irq) // see R15
        else $error("loss change interrupt missing");

    c_reframe: cover property (@(posedge clock) reframe);
    c_oof: cover property (@(posedge clock)
        state_r == e3fm_pkg::ST_OOF);
    c_lof: cover property (@(posedge clock)
        state_r == e3fm_pkg::ST_LOF);
    c_relock: cover property (@(posedge clock)
        state_r == e3fm_pkg::ST_OOF ##1 state_r == e3fm_pkg::ST_IN_FRAME);
endmodule : e3fm_frame_maint
`default_nettype wire

// ---- e3fm_defs.svh ----
// Purpose: Offsets, field positions, reset values and counts for the
//          receive E3 frame maintenance block.
// Assumes: 8-bit register port, E3 frame of 1536 bits.
// Notes:   Definitions only.
// Function
// R1 - While locked, check each frame for the alignment pattern at its place.
// R2 - Go out of frame only after four consecutive bad patterns.
// R3 - Each bad pattern increments the 16-bit error counter at 0x52/0x53.
// R4 - Counter bytes are read-only, clear when read, start from zero.
// R5 - Writing one to bit 0 at 0x01 forces alignment search.
// R6 - Reframe drives out-of-frame and loss-of-frame pins high.
// R7 - Reframe raises both out-of-frame and loss-of-frame change interrupts.
// R8 - Reframe sets status bits 6 and 5 of register 0x11.
// R9 - Pins encode state; loss high with out-of-frame low never occurs.
// R10 - Thirty-two consecutive zero line bits declare loss of signal.
// R11 - External loss input also declares loss of signal.
// R12 - Bit 7 of 0x11 limits out-of-frame dwell to 24 or 8 frames.
// R13 - Change interrupts set bits 3 and 2 of 0x14, cleared on read.
// R14 - Loss of signal drives its pin high and sets bit 4 of 0x11.
// R15 - Loss clears after 32 bits without four zeros; interrupt, bit, pin.
// R16 - Error counter saturates at its maximum instead of wrapping.
`ifndef E3FM_DEFS_SVH
`define E3FM_DEFS_SVH

`define E3FM_ADDR_IO_CTRL   8'h01
`define E3FM_ADDR_CFG_STAT  8'h11
`define E3FM_ADDR_INT_STAT  8'h14
`define E3FM_ADDR_INT_MASK  8'h15
`define E3FM_ADDR_ERR_HIGH  8'h52
`define E3FM_ADDR_ERR_LOW   8'h53

`define E3FM_IO_REFRAME_BIT 0
`define E3FM_IO_CLK_INV_BIT 1
`define E3FM_IO_RESET       8'hA0
`define E3FM_IO_WR_MASK     8'hBE

`define E3FM_CFG_ALGO_BIT   7
`define E3FM_CFG_LOF_BIT    6
`define E3FM_CFG_OOF_BIT    5
`define E3FM_CFG_LOS_BIT    4

`define E3FM_INT_OOF_BIT    3
`define E3FM_INT_LOF_BIT    2
`define E3FM_INT_LOS_BIT    1
`define E3FM_INT_USED       8'h0E

`define E3FM_FRAME_BITS     11'd1536
`define E3FM_FAS_LAST       11'd9
`define E3FM_FAS_NEXT       11'd10
`define E3FM_FAS_PATTERN    10'h3D0
`define E3FM_MISS_LIMIT     3'd4
`define E3FM_DWELL_LONG     5'd24
`define E3FM_DWELL_SHORT    5'd8
`define E3FM_LOS_ZEROS      6'd32
`define E3FM_LOS_CLEAN      6'd32
`define E3FM_LOS_RUN        6'd4
`define E3FM_CNT_MAX        16'hFFFF

`endif

// ---- e3fm_pkg.sv ----
// Purpose: Types shared by the frame maintenance block.
// Assumes: Nothing beyond the constants header.
// Notes:   Framing states only.
package e3fm_pkg;
    typedef enum logic [1:0] {
        ST_SEARCH,
        ST_IN_FRAME,
        ST_OOF,
        ST_LOF
    } e3fm_state_e;
endpackage : e3fm_pkg

// ---- e3fm_sync.sv ----
// Purpose: Two-flop synchroniser for pins from outside the clock domain.
// Assumes: Each bit is an independent level.
// Notes:   Only the second flop is visible outside.
`timescale 1ns/1ps
`default_nettype none
module e3fm_sync #(
    parameter int W = 1
) (
    input  wire logic         clock,
    input  wire logic         sys_rst,
    input  wire logic [W-1:0] d,
    output var  logic [W-1:0] q
);
    logic [W-1:0] meta_r;

    // First flop feeds only the second
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            meta_r <= '0;
            q      <= '0;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule : e3fm_sync
`default_nettype wire

// ---- e3fm_los_detect.sv ----
// Purpose: Declares and clears loss of signal from line bit content.
// Assumes: bit_en pulses once per received line bit.
// Notes:   Counters saturate at 32.
`timescale 1ns/1ps
`default_nettype none
`include "e3fm_defs.svh"
module e3fm_los_detect (
    input  wire logic clock,
    input  wire logic sys_rst,
    input  wire logic bit_en,
    input  wire logic bit_val,
    output var  logic los_r
);
    logic [5:0] zero_run_r;
    logic [5:0] clean_r;
    wire  [5:0] zero_run_nxt;
    wire  [5:0] clean_nxt;
    wire        run4;

    // Zero run length and bits since the last run of four zeros
    assign zero_run_nxt = bit_val ? 6'h00 :
        (zero_run_r == `E3FM_LOS_ZEROS) ? zero_run_r : zero_run_r + 6'h01;
    assign run4      = zero_run_nxt >= `E3FM_LOS_RUN;
    assign clean_nxt = run4 ? 6'h00 :
        (clean_r == `E3FM_LOS_CLEAN) ? clean_r : clean_r + 6'h01;

    // Set on 32 zeros, clear on 32 clean bits
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            zero_run_r <= 6'h00;
            clean_r    <= 6'h00;
            los_r      <= 1'b0;
        end else if (bit_en) begin
            zero_run_r <= zero_run_nxt;
            clean_r    <= clean_nxt;
            if (zero_run_nxt == `E3FM_LOS_ZEROS)
                los_r <= 1'b1;                        // see R10
            else if (los_r && clean_nxt == `E3FM_LOS_CLEAN)
                los_r <= 1'b0;                        // see R15
        end
    end

    property p_los_set;
        @(posedge clock) disable iff (sys_rst)
        (bit_en && !bit_val && zero_run_r == 6'd31) |=> los_r;
    endproperty
    a_los_set: assert property (p_los_set) // see R10
        else $error("loss not declared after 32 zeros");

    property p_los_clear;
        @(posedge clock) disable iff (sys_rst)
        $fell(los_r) |-> (clean_r == `E3FM_LOS_CLEAN);
    endproperty
    a_los_clear: assert property (p_los_clear) // see R15
        else $error("loss cleared without a clean stretch");

    c_los_set: cover property (@(posedge clock) $rose(los_r));
endmodule : e3fm_los_detect
`default_nettype wire

// ---- e3fm_liu_model.sv ----
// Purpose: Line interface model that feeds E3 line bits and a loss flag.
// Assumes: Line clock period of 160 ns, running only while bits are sent.
// Notes:   Marks alternate between the two rails, as on a bipolar line.
`timescale 1ns/1ps
`default_nettype none
`include "e3fm_defs.svh"
module e3fm_liu_model (
    output var logic line_clk,
    output var logic pos_d,
    output var logic neg_d,
    output var logic ext_loss
);
    logic rail_sel;

    // Rails, clock and loss flag at rest
    initial begin
        rail_sel = 1'b0;
        line_clk = 1'b0;
        pos_d    = 1'b0;
        neg_d    = 1'b0;
        ext_loss = 1'b0;
    end

    // One bit: data set while the clock is low, taken at its rise
    task automatic send_bit(input logic b);
        pos_d    <= b & ~rail_sel;
        neg_d    <= b & rail_sel;
        rail_sel = rail_sel ^ b;
        #80;
        line_clk <= 1'b1;
        #80;
        line_clk <= 1'b0;
    endtask : send_bit

    // Frame start; a bad frame has its first pattern bit inverted
    task automatic send_frame(input logic good, input int nbits);
        logic [9:0] pat;
        pat = `E3FM_FAS_PATTERN;
        for (int i = 0; i < nbits; i++) begin
            if (i < 10)
                send_bit(pat[9-i] ^ (i == 0 && !good));
            else
                send_bit(1'b1);
        end
    endtask : send_frame

    // Run of equal bits, zeros for a dead line
    task automatic send_run(input logic b, input int n);
        repeat (n) send_bit(b);
    endtask : send_run

    // Loss flag raised or dropped by the line interface
    task automatic set_ext(input logic v);
        ext_loss <= v;
    endtask : set_ext
endmodule : e3fm_liu_model
`default_nettype wire

// ---- testbench.sv ----
// Purpose: Self-checking bench for the receive frame maintenance block.
// Assumes: Line bits take about three clocks to reach the framing logic.
// Notes:   Dwell to loss of frame and counter saturation are not run.
`timescale 1ns/1ps
`default_nettype none
`include "e3fm_defs.svh"
module testbench;
    logic       clock = 1'b0;
    logic       sys_rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic       reg_wr = 1'b0;
    logic       reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic       lclk, pos_d, neg_d, ext_loss;
    logic       out_of_frame_state, loss_of_frame_state, los, irq;
    int         fail_count = 0;
    int         n_checks = 0;
    logic [7:0] row_addr [7] = '{8'h01, 8'h11, 8'h14, 8'h15,
                                 8'h52, 8'h53, 8'h30};
    logic [7:0] row_exp  [7] = '{8'hA0, 8'h60, 8'h00, 8'h00,
                                 8'h00, 8'h00, 8'h00};

    // 125 MHz clock
    always #4 clock = ~clock;

    e3fm_liu_model u_liu (.line_clk(lclk), .pos_d(pos_d), .neg_d(neg_d),
                          .ext_loss(ext_loss));

    e3fm_frame_maint DUT (
        .clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .line_clk_in(lclk),
        .line_data_positive_input(pos_d),
        .line_data_negative_input(neg_d),
        .external_signal_loss_input(ext_loss),
        .out_of_frame_indicator(out_of_frame_state), .loss_of_frame_indicator(loss_of_frame_state),
        .signal_loss_indicator(los), .irq(irq));

    // Pin pair must never show loss of frame without out of frame
    always @(posedge clock) begin
        if (!sys_rst && loss_of_frame_state === 1'b1 && out_of_frame_state === 1'b0) begin
            fail_count++;
            $display("[ERR] frame pins exp not 10 got %b%b", loss_of_frame_state, out_of_frame_state);
        end
    end

    task automatic chk_byte(input string nm, input logic [7:0] e,
                            input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask : chk_byte

    // Pins compared as {loss of frame, out of frame, loss, irq}
    task automatic chk_pins(input string nm, input logic [3:0] e);
        n_checks++;
        if ({loss_of_frame_state, out_of_frame_state, los, irq} !== e) begin
            fail_count++;
            $display("[ERR] %s exp %b got %b", nm, e, {loss_of_frame_state, out_of_frame_state, los, irq});
        end
    endtask : chk_pins

    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr    <= 1'b0;
    endtask : reg_write

    // Read data stands only in the cycle after the strobe
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e,
                          input string nm);
        @(posedge clock);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd   <= 1'b0;
        #1;
        chk_byte(nm, e, reg_rdata);
    endtask : rd_chk

    task automatic settle();
        repeat (20) @(posedge clock);
        #1;
    endtask : settle

    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : summarize

    // Watchdog, about a third beyond the expected run of one millisecond
    initial begin
        #1300000;
        fail_count++;
        $display("[ERR] watchdog exp done got hang");
        summarize();
    end

    // Main sequence
    initial begin
        repeat (20) @(posedge clock);
        sys_rst <= 1'b0;
        settle();
        chk_pins("pins reset", 4'b1100);
        for (int i = 0; i < 7; i++)
            rd_chk(row_addr[i], row_exp[i], "reset value");
        $display("test reset done");
        u_liu.send_frame(1'b1, 1536);
        settle();
        chk_pins("pins locked", 4'b0000);
        rd_chk(`E3FM_ADDR_INT_STAT, 8'h0C, "int lock");
        rd_chk(`E3FM_ADDR_INT_STAT, 8'h00, "int cleared");
        rd_chk(`E3FM_ADDR_CFG_STAT, 8'h00, "status lock");
        repeat (3) u_liu.send_frame(1'b0, 1536);
        settle();
        chk_pins("pins three misses", 4'b0000);
        reg_write(`E3FM_ADDR_ERR_LOW, 8'hFF);
        rd_chk(`E3FM_ADDR_ERR_HIGH, 8'h00, "count high");
        rd_chk(`E3FM_ADDR_ERR_LOW, 8'h03, "count low");
        rd_chk(`E3FM_ADDR_ERR_LOW, 8'h00, "count cleared");
        reg_write(`E3FM_ADDR_INT_MASK, 8'h0E);
        u_liu.send_frame(1'b0, 10);
        settle();
        chk_pins("pins out of frame", 4'b0101);
        rd_chk(`E3FM_ADDR_INT_STAT, 8'h08, "int oof");
        rd_chk(`E3FM_ADDR_CFG_STAT, 8'h20, "status oof");
        rd_chk(`E3FM_ADDR_ERR_LOW, 8'h01, "count fourth");
        chk_pins("irq cleared", 4'b0100);
        $display("test maintenance done");
        reg_write(`E3FM_ADDR_IO_CTRL, 8'hA1);
        rd_chk(`E3FM_ADDR_CFG_STAT, 8'h60, "status reframe");
        settle();
        chk_pins("pins reframe", 4'b1101);
        rd_chk(`E3FM_ADDR_INT_STAT, 8'h0C, "int reframe");
        rd_chk(`E3FM_ADDR_IO_CTRL, 8'hA0, "io control");
        $display("test reframe done");
        u_liu.send_run(1'b1, 8);
        u_liu.send_run(1'b0, 31);
        settle();
        chk_pins("pins 31 zeros", 4'b1100);
        u_liu.send_run(1'b0, 1);
        settle();
        chk_pins("pins 32 zeros", 4'b1111);
        rd_chk(`E3FM_ADDR_CFG_STAT, 8'h70, "status loss");
        rd_chk(`E3FM_ADDR_INT_STAT, 8'h02, "int loss");
        u_liu.send_run(1'b1, 32);
        settle();
        chk_pins("pins loss cleared", 4'b1101);
        rd_chk(`E3FM_ADDR_CFG_STAT, 8'h60, "status clear");
        rd_chk(`E3FM_ADDR_INT_STAT, 8'h02, "int clear");
        u_liu.set_ext(1'b1);
        settle();
        chk_pins("pins external", 4'b1111);
        rd_chk(`E3FM_ADDR_INT_STAT, 8'h02, "int external");
        u_liu.set_ext(1'b0);
        u_liu.send_run(1'b1, 32);
        settle();
        chk_pins("pins external gone", 4'b1101);
        reg_write(`E3FM_ADDR_INT_STAT, 8'h02);
        rd_chk(`E3FM_ADDR_INT_STAT, 8'h00, "int write clear");
        reg_write(`E3FM_ADDR_CFG_STAT, 8'hFF);
        rd_chk(`E3FM_ADDR_CFG_STAT, 8'hE0, "dwell select");
        $display("test loss done");
        summarize();
    end
endmodule : testbench
`default_nettype wire
